// [sac_pkg.sv]
package sac_pkg;
    // word indices: the byte address on the bus is four times the index
    localparam logic [7:0] IDX_PIN_SEL = 8'h05;
    localparam logic [7:0] IDX_CONV_CTRL = 8'h06;
    localparam logic [7:0] IDX_OFS_PD = 8'h07;
    localparam logic [7:0] IDX_RES_HIGH = 8'h08;
    localparam logic [7:0] IDX_RES_LOW = 8'h09;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h0a;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h0b;
    localparam logic [7:0] IDX_WAKE_CTRL = 8'h0c;
    localparam int ADDR_W = 8;
    localparam int ADDR_LSB = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // converter_control, offset and result fields
    localparam int CC_REF_BIT = 7;
    localparam int CC_CKR_HI = 6;
    localparam int CC_CKR_LO = 5;
    localparam int CC_RUN_BIT = 4;
    localparam int CC_PWR_BIT = 3;
    localparam int CC_CH_HI = 2;
    localparam int OPD_PDE_BIT = 2;
    localparam logic [7:0] OPD_MASK = 8'h04;
    localparam int RES_W = 12;
    localparam int RES_SPLIT = 4;

    localparam logic [1:0] CKR_DIV4 = 2'h0;
    localparam logic [1:0] CKR_DIV1 = 2'h1;
    localparam logic [1:0] CKR_DIV16 = 2'h2;
    localparam logic [1:0] CKR_DIV2 = 2'h3;
    localparam logic [4:0] DIV_4 = 5'h04;
    localparam logic [4:0] DIV_1 = 5'h01;
    localparam logic [4:0] DIV_16 = 5'h10;
    localparam logic [4:0] DIV_2 = 5'h02;

    // sample-and-hold periods preceding the bit decisions
    localparam logic [3:0] SH_DIV4 = 4'h8;
    localparam logic [3:0] SH_DIV1 = 4'h4;
    localparam logic [3:0] SH_DIV16 = 4'hc;
    localparam logic [3:0] SH_DIV2 = 4'h4;

    localparam logic [3:0] MUX_HALF_SUPPLY = 4'h8;

    typedef struct packed {
        logic ref_ext;
        logic [1:0] clock_rate;
        logic conversion_run;
        logic converter_power_on;
        logic [2:0] channel_sel;
    } sac_ctrl_t;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} sac_state_t;
endpackage

// [sac_adc_ctrl.sv]
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
// How it works
// - pin-select bit n routes pin n analog
// - external interrupt beats port on pin 0
// - reference bit: 0 internal, 1 external pin
// - clock field divides oscillator 4,1,16,2
// - writing run bit starts a conversion
// - hardware clears run; software zero ignored
// - power bit zero switches reference off
// - channel field selects analog input 0-7
// - offset register bits 7-3 read zero
// - power-detect bit forces half-supply input
// - completion loads result, clears run, flags
// - 12-bit successive approximation result
// - mux offers eight channels plus half-supply
// - flag sets regardless of enables
// - sleep: wake if enabled, else power off
module sac_adc_ctrl
    import sac_pkg::*;
#(
    parameter int NCH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cpu_sleep,
    input wire logic ext_int_enable,
    input wire logic comp_in,
    output logic [NCH-1:0] pin_analog_enable,
    output logic pin0_ext_int_sel,
    output logic pin0_port_sel,
    output logic ref_ext_sel,
    output logic ref_pin_is_port,
    output logic ref_power_on,
    output logic [3:0] mux_sel,
    output logic dac_enable,
    output logic [RES_W-1:0] dac_code,
    output logic sample_hold,
    output logic cpu_wake,
    output logic irq
);
    sac_ctrl_t ctrl_q;
    logic [NCH-1:0] pin_sel_q;
    logic pde_q, mask_q, wake_en_q, flag_q;
    logic [RES_W-1:0] result_q, trial_q;
    sac_state_t state_q;
    logic [4:0] pre_q;
    logic [3:0] cnt_q;
    logic cmp_s1_q, cmp_s2_q, slp_s1_q, slp_s2_q, intsel_s1_q, intsel_s2_q;
    logic aw_held_q, w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;

    // comparator and sleep come from other domains
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {cmp_s1_q, cmp_s2_q, slp_s1_q, slp_s2_q} <= 4'h0;
            {intsel_s1_q, intsel_s2_q} <= 2'h0;
        end else begin
            cmp_s1_q <= comp_in;
            cmp_s2_q <= cmp_s1_q;
            slp_s1_q <= cpu_sleep;
            slp_s2_q <= slp_s1_q;
            intsel_s1_q <= ext_int_enable;
            intsel_s2_q <= intsel_s1_q;
        end
    end

    function automatic logic [4:0] div_of(input logic [1:0] c);
        unique case (c)
            CKR_DIV4: div_of = DIV_4;
            CKR_DIV1: div_of = DIV_1;
            CKR_DIV16: div_of = DIV_16;
            CKR_DIV2: div_of = DIV_2;
        endcase
    endfunction

    function automatic logic [3:0] sh_of(input logic [1:0] c);
        unique case (c)
            CKR_DIV4: sh_of = SH_DIV4;
            CKR_DIV1: sh_of = SH_DIV1;
            CKR_DIV16: sh_of = SH_DIV16;
            CKR_DIV2: sh_of = SH_DIV2;
        endcase
    endfunction

    // write channel: both halves may arrive in either order
    wire wr_fire = (aw_held_q || s_axi_awvalid) && (w_held_q || s_axi_wvalid) && !s_axi_bvalid;
    wire [ADDR_W-1:0] wr_byte_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    // word index; an unaligned byte address maps to no register
    wire [ADDR_W-1:0] wr_addr = (wr_byte_addr[ADDR_LSB-1:0] == '0)
        ? (wr_byte_addr >> ADDR_LSB) : '1;
    wire [7:0] wr_data = w_held_q ? wdata_q : s_axi_wdata[7:0];
    wire wr_lane0 = w_held_q ? 1'b1 : s_axi_wstrb[0];
    wire wr_ok = wr_fire && wr_lane0;
    wire wr_pin = wr_ok && wr_addr == IDX_PIN_SEL;
    wire wr_ctrl = wr_ok && wr_addr == IDX_CONV_CTRL;
    wire wr_opd = wr_ok && wr_addr == IDX_OFS_PD;
    wire wr_sts = wr_ok && wr_addr == IDX_IRQ_STATUS;
    wire wr_msk = wr_ok && wr_addr == IDX_IRQ_MASK;
    wire wr_wak = wr_ok && wr_addr == IDX_WAKE_CTRL;
    wire wr_mapped = wr_addr inside {IDX_PIN_SEL, IDX_CONV_CTRL, IDX_OFS_PD, IDX_RES_HIGH,
        IDX_RES_LOW, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_WAKE_CTRL};

    // converter sequencing
    wire tick = (pre_q == 5'h01);
    wire start = wr_ctrl && wr_data[CC_RUN_BIT] && state_q == ST_IDLE;
    // a start write's own rate applies from the first period
    wire [1:0] rate_now = start ? wr_data[CC_CKR_HI:CC_CKR_LO] : ctrl_q.clock_rate;
    wire done = state_q == ST_CONVERT && tick && cnt_q == 4'h0;
    // sleep without wake enable shuts off
    wire sleep_off = done && slp_s2_q && !wake_en_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            pre_q <= 5'h01;
            cnt_q <= 4'h0;
            trial_q <= '0;
        end else begin
            pre_q <= (tick || start) ? div_of(rate_now) : 5'(pre_q - 5'h01);
            unique case (state_q)
                ST_IDLE: if (start) begin
                    state_q <= ST_SAMPLE;
                    cnt_q <= 4'(sh_of(rate_now) - 4'h1);
                end
                ST_SAMPLE: if (tick) begin
                    if (cnt_q == 4'h0) begin
                        state_q <= ST_CONVERT;
                        cnt_q <= 4'(RES_W - 1);
                        trial_q <= 12'h800;
                    end else begin
                        cnt_q <= 4'(cnt_q - 4'h1);
                    end
                end
                ST_CONVERT: if (tick) begin
                    trial_q <= (cmp_s2_q ? trial_q : (trial_q & ~(12'h800 >> (4'(RES_W-1) - cnt_q))))
                        | ((cnt_q == 4'h0) ? 12'h000 : (12'h800 >> (4'(RES_W) - cnt_q)));
                    if (cnt_q == 4'h0) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= 4'(cnt_q - 4'h1);
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    wire [RES_W-1:0] final_code = cmp_s2_q ? trial_q : (trial_q & 12'hffe);

    // registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_sel_q <= '0;
            ctrl_q <= '0;
            pde_q <= 1'b0;
            mask_q <= 1'b0;
            wake_en_q <= 1'b0;
            flag_q <= 1'b0;
            result_q <= '0;
        end else begin
            if (wr_pin) pin_sel_q <= wr_data[NCH-1:0];
            if (wr_ctrl) begin
                ctrl_q.ref_ext <= wr_data[CC_REF_BIT];
                ctrl_q.clock_rate <= wr_data[CC_CKR_HI:CC_CKR_LO];
                ctrl_q.channel_sel <= wr_data[CC_CH_HI:0];
            end
            if (sleep_off) ctrl_q.converter_power_on <= 1'b0;
            else if (wr_ctrl) ctrl_q.converter_power_on <= wr_data[CC_PWR_BIT];
            if (done) ctrl_q.conversion_run <= 1'b0;
            else if (start) ctrl_q.conversion_run <= 1'b1;
            if (wr_opd) pde_q <= wr_data[OPD_PDE_BIT];
            if (wr_msk) mask_q <= wr_data[0];
            if (wr_wak) wake_en_q <= wr_data[0];
            // load and flag, set beats clear
            if (done) begin
                result_q <= final_code;
                flag_q <= 1'b1;
            end else if (wr_sts && wr_data[0]) begin
                flag_q <= 1'b0;
            end
        end
    end

    wire [7:0] res_high = result_q[RES_W-1:RES_SPLIT];
    wire [7:0] res_low = {4'h0, result_q[RES_SPLIT-1:0]};
    wire [ADDR_W-1:0] rd_idx = (s_axi_araddr[ADDR_LSB-1:0] == '0)
        ? (s_axi_araddr >> ADDR_LSB) : '1;
    wire [7:0] rd_byte = (rd_idx == IDX_PIN_SEL) ? 8'(pin_sel_q)
        : (rd_idx == IDX_CONV_CTRL) ? ctrl_q
        : (rd_idx == IDX_OFS_PD) ? ({7'h00, pde_q} << OPD_PDE_BIT) & OPD_MASK
        : (rd_idx == IDX_RES_HIGH) ? res_high
        : (rd_idx == IDX_RES_LOW) ? res_low
        : (rd_idx == IDX_IRQ_STATUS) ? {7'h00, flag_q}
        : (rd_idx == IDX_IRQ_MASK) ? {7'h00, mask_q}
        : (rd_idx == IDX_WAKE_CTRL) ? {7'h00, wake_en_q} : 8'h00;
    wire rd_mapped = rd_idx inside {IDX_PIN_SEL, IDX_CONV_CTRL, IDX_OFS_PD, IDX_RES_HIGH,
        IDX_RES_LOW, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_WAKE_CTRL};

    // bus slave handshakes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // outputs, all registered
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_analog_enable <= '0;
            pin0_ext_int_sel <= 1'b0;
            pin0_port_sel <= 1'b1;
            ref_ext_sel <= 1'b0;
            ref_pin_is_port <= 1'b1;
            ref_power_on <= 1'b0;
            mux_sel <= 4'h0;
            dac_enable <= 1'b0;
            dac_code <= '0;
            sample_hold <= 1'b0;
            cpu_wake <= 1'b0;
            irq <= 1'b0;
        end else begin
            pin_analog_enable <= pin_sel_q;
            // interrupt over port on pin 0
            pin0_ext_int_sel <= intsel_s2_q;
            pin0_port_sel <= !intsel_s2_q && !pin_sel_q[0];
            ref_ext_sel <= ctrl_q.ref_ext;
            ref_pin_is_port <= !ctrl_q.ref_ext;
            ref_power_on <= ctrl_q.converter_power_on;
            mux_sel <= pde_q ? MUX_HALF_SUPPLY : {1'b0, ctrl_q.channel_sel};
            dac_enable <= state_q == ST_CONVERT;
            dac_code <= trial_q;
            sample_hold <= state_q == ST_SAMPLE;
            cpu_wake <= done && slp_s2_q && wake_en_q;
            irq <= flag_q && mask_q;
        end
    end
endmodule

// [sac_adc_ctrl_sva.sv]
`timescale 1ns/1ns
module sac_chk
    import sac_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic pin0_ext_int_sel,
    input wire logic pin0_port_sel,
    input wire logic ref_ext_sel,
    input wire logic ref_pin_is_port,
    input wire logic [3:0] mux_sel,
    input wire logic cpu_wake
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_pin0_int_wins: assert property (pin0_ext_int_sel |-> !pin0_port_sel) // priority
        else $error("pin 0 claimed by port and interrupt");
    a_ref_one_owner: assert property (ref_ext_sel != ref_pin_is_port) // reference pin
        else $error("reference pin ownership wrong");
    a_mux_nine_src: assert property (mux_sel <= 4'h8) // mux sources
        else $error("mux select out of range");
    a_wake_one_cycle: assert property (cpu_wake |=> !cpu_wake) // wake pulse
        else $error("wake longer than one cycle");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) // write reply
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) // read
        else $error("read response late");
    a_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) // zero
        else $error("upper read bits set");
    a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
        |-> s_axi_rdata == 32'h0) // unmapped data
        else $error("refused read carries data");
endmodule
bind sac_adc_ctrl sac_chk chk_u (.clk(clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .pin0_ext_int_sel(pin0_ext_int_sel),
    .pin0_port_sel(pin0_port_sel), .ref_ext_sel(ref_ext_sel),
    .ref_pin_is_port(ref_pin_is_port), .mux_sel(mux_sel), .cpu_wake(cpu_wake));

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top
    import sac_pkg::*;
;
    logic clk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, slp = 0, eie = 0;
    logic cmp = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0;
    logic [3:0] ws = 4'hf;
    wire awr, wrdy, bv, arr, rv, pe0, pp0, rex, rpp, rpo, wk, irq, sho, dae;
    wire [11:0] dco;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    wire [7:0] pae;
    wire [3:0] mux;
    int fail_count = 0, compares = 0, cyc = 0, t0, wakes = 0, busy_n = 0;
    int exp_t[4] = '{80, 16, 384, 32};
    logic [31:0] d;
    logic [1:0] r;
    sac_adc_ctrl dut_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .cpu_sleep(slp),
        .ext_int_enable(eie), .comp_in(cmp), .pin_analog_enable(pae), .pin0_ext_int_sel(pe0),
        .pin0_port_sel(pp0), .ref_ext_sel(rex), .ref_pin_is_port(rpp), .ref_power_on(rpo),
        .mux_sel(mux), .dac_enable(dae), .dac_code(dco), .sample_hold(sho), .cpu_wake(wk),
        .irq(irq));
    initial begin
        forever #10 clk = ~clk;
    end
    task report_and_stop;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (wk) wakes++;
        busy_n += int'(sho) + int'(dae);
        if (cyc == 20000) begin
            fail_count++;
            $display("Error %0t: timeout", $time);
            report_and_stop();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // handshake sampled at the negedge so the posedge update never races the bench
    task wr(input logic [7:0] a, input logic [7:0] v);
        logic ad, dd, bd;
        ad = 0;
        dd = 0;
        bd = 0;
        @(posedge clk);
        awa <= {a[5:0], 2'b00};
        wd <= {24'h0, v};
        awv <= 1;
        wv <= 1;
        bry <= 1;
        while (!bd) begin
            @(negedge clk);
            ad = ad | awr;
            dd = dd | wrdy;
            bd = bv;
            r = br;
            @(posedge clk);
            if (ad) awv <= 0;
            if (dd) wv <= 0;
            if (bd) bry <= 0;
        end
    endtask
    task rd(input logic [7:0] a);
        logic ad, dn;
        ad = 0;
        dn = 0;
        @(posedge clk);
        ara <= {a[5:0], 2'b00};
        arv <= 1;
        rry <= 1;
        while (!dn) begin
            @(negedge clk);
            ad = ad | arr;
            dn = rv;
            d = rdat;
            r = rr;
            @(posedge clk);
            if (ad) arv <= 0;
            if (dn) rry <= 0;
        end
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(d, {24'h0, e});
    endtask
    task conv(input logic [7:0] c, input int e);
        // two slowest periods before each start
        repeat (2 * DIV_16) @(posedge clk);
        busy_n = 0;
        wr(IDX_CONV_CTRL, c | 8'h10);
        t0 = cyc;
        wr(IDX_CONV_CTRL, c);
        rd(IDX_CONV_CTRL);
        chk(d[4], 1'b1); // zero write ignored
        while (d[4] && cyc - t0 < 600) rd(IDX_CONV_CTRL);
        chk(d[4], 1'b0); // run cleared
        chk(cyc - t0 >= e - 4 && cyc - t0 <= e + 8, 1'b1); // divider time
        chk(busy_n, e); // sample and bit periods
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1;
        rchk(IDX_CONV_CTRL, 8'h00); // default internal
        rchk(IDX_OFS_PD, 8'h00); // default off
        chk({pp0, rpp}, 2'b11); // pins as port
        $display("reset test done");
        wr(IDX_PIN_SEL, 8'ha4);
        rchk(IDX_PIN_SEL, 8'ha4); // select bits
        chk(pae, 8'ha4); // analog routes
        eie <= 1;
        repeat (6) @(negedge clk);
        chk({pe0, pp0}, 2'b10); // interrupt wins
        $display("pin test done");
        wr(IDX_OFS_PD, 8'hf8); // reserved low bits zero
        rchk(IDX_OFS_PD, 8'h00); // unused bits
        wr(IDX_OFS_PD, 8'hfc); // reserved low bits zero
        rchk(IDX_OFS_PD, 8'h04); // detect bit
        wr(IDX_CONV_CTRL, 8'h8d);
        @(negedge clk);
        chk({rex, rpp, rpo, mux}, {3'b101, 4'h8}); // half supply
        wr(IDX_OFS_PD, 8'h00);
        wr(IDX_CONV_CTRL, 8'h05);
        @(negedge clk);
        chk({rex, rpo, mux}, {2'b00, 4'h5}); // channel
        $display("control test done");
        wr(IDX_IRQ_MASK, 8'h01);
        // every rate code tried, timing in clock cycles
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            cmp <= k[0];
            conv({1'b0, k[1:0], 2'b01, 3'(k + 4)}, exp_t[k]); // start
            @(negedge clk);
            chk({irq, mux}, {1'b1, 4'(k + 4)}); // flag and mux
            chk(dco, k[0] ? 12'hfff : 12'h000); // final trial code
            rchk(IDX_RES_HIGH, k[0] ? 8'hff : 8'h00); // high part
            rchk(IDX_RES_LOW, k[0] ? 8'h0f : 8'h00); // low part
            wr(IDX_IRQ_STATUS, 8'h01);
            rchk(IDX_IRQ_STATUS, 8'h00); // flag cleared
            @(negedge clk);
            chk(irq, 1'b0); // irq drops
        end
        $display("conversion test done");
        wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_WAKE_CTRL, 8'h01);
        slp <= 1;
        conv(8'h28, 16); // wake
        chk(wakes, 1); // one wake pulse
        @(negedge clk);
        chk(irq, 1'b0); // masked
        rchk(IDX_IRQ_STATUS, 8'h01); // flag set
        rchk(IDX_CONV_CTRL, 8'h28); // power kept
        wr(IDX_WAKE_CTRL, 8'h00);
        conv(8'h28, 16); // no wake
        rchk(IDX_CONV_CTRL, 8'h20); // power off
        chk(wakes, 1); // no wake without enable
        $display("sleep test done");
        rd(8'h20);
        chk(r, RESP_SLVERR); // unmapped read refused
        chk(d, 32'h0); // unmapped read data
        wr(8'h20, 8'hff);
        chk(r, RESP_SLVERR); // unmapped write
        $display("bus test done");
        report_and_stop();
    end
endmodule
